// [src/cms_pkg.sv]
// Constants, types and decode functions of the clock mode selector
package cms_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CTRL1_HGO = 7;
  localparam int CTRL1_RANGE = 6;
  localparam int CTRL1_REFERENCE_SELECT = 5;
  localparam int CTRL1_REQ = 3;
  localparam int CTRL2_MFD = 4;
  localparam int CTRL2_RFD = 0;
  localparam int STAT_MODE = 0;
  localparam int STAT_OSC_STABLE_FLAG = 2;
  localparam int STAT_EXT_REF_OK = 3;
  localparam int STAT_CLOCK_LOSS_FLAG = 4;
  localparam int STAT_LOCK = 5;
  localparam int STAT_AMP = 6;
  localparam int STAT_HGSEL = 7;
  localparam logic [1:0] REQ_RESET = 2'h0;
  localparam logic [2:0] FIELD_RESET = 3'h0;

  // ----------------------------------------
  // Mode codes and output selections
  // ----------------------------------------
  localparam logic [1:0] MODE_SCM = 2'h0;
  localparam logic [1:0] MODE_FEI = 2'h1;
  localparam logic [1:0] MODE_FBE = 2'h2;
  localparam logic [1:0] MODE_FEE = 2'h3;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_DCO = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] FIX_OFF = 2'h0;
  localparam logic [1:0] FIX_BUS = 2'h1;
  localparam logic [1:0] FIX_EXT_HALF = 2'h2;

  // ----------------------------------------
  // Timing and ratio constants
  // ----------------------------------------
  localparam int SETTLE_CYCLES = 4;
  localparam logic [7:0] INT_REF_DIV = 8'h07;
  localparam logic [7:0] INT_COMP_PERIODS = 8'h08;
  localparam logic [7:0] EXT_COMP_LOW = 8'h02;
  localparam logic [7:0] EXT_COMP_HIGH = 8'h80;
  localparam logic [11:0] FIXED_MIN_RATIO = 12'h004;

  typedef enum logic [2:0] {ST_OFF, ST_SCM, ST_FEI, ST_FBE, ST_FEE} cms_state_t;

  // Multiplier 4..18 from the three-bit field
  function automatic logic [4:0] cms_mult(input logic [2:0] multiplier_field);
    return 5'h04 + {1'b0, multiplier_field, 1'b0};
  endfunction : cms_mult

  // Prescale 64 in low range, 1 in high range
  function automatic logic [6:0] cms_prescale(input logic range);
    return range ? 7'h01 : 7'h40;
  endfunction : cms_prescale

  function automatic logic [1:0] cms_code(input cms_state_t st);
    unique case (st)
      ST_FEI: return MODE_FEI;
      ST_FBE: return MODE_FBE;
      ST_FEE: return MODE_FEE;
      ST_OFF, ST_SCM: return MODE_SCM;
    endcase
  endfunction : cms_code

endpackage : cms_pkg

// [src/cms_route_if.sv]
// Bundle between the mode machine and the clock routing logic
interface cms_route_if;
  import cms_pkg::*;
  cms_state_t state;
  logic halfRate;
  logic fllLock;
  logic range;
  logic [2:0] multiplier_field;
  logic [2:0] reduction_field;
  logic [1:0] genSource;
  logic [3:0] genDivShift;
  logic [1:0] fixedSel;
  logic [7:0] compPeriods;
  logic [7:0] refDivide;
  modport ctrl (output state, halfRate, fllLock, range, multiplier_field, reduction_field,
                input genSource, genDivShift, fixedSel, compPeriods, refDivide);
  modport route (input state, halfRate, fllLock, range, multiplier_field, reduction_field,
                 output genSource, genDivShift, fixedSel, compPeriods, refDivide);
endinterface : cms_route_if

// [src/cms_req_settle.sv]
// Delays the requested mode until it has been stable for a number of cycles
module cms_req_settle
  import cms_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] reqIn,
  output logic [1:0] reqOut
);

  // Counter is eight bits and needs a non-zero window
  if (SETTLE < 2 || SETTLE > 255)
  begin : g_bad_settle
    $error("cms_req_settle: SETTLE out of range");
  end

  logic [1:0] held_reg;
  logic [7:0] cnt_reg;
  logic [1:0] reqOut_reg;
  wire changed = reqIn != held_reg;
  wire done = cnt_reg == 8'(SETTLE - 1);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      held_reg <= REQ_RESET;
      cnt_reg <= 8'h00;
      reqOut_reg <= REQ_RESET;
    end
    else
    begin
      held_reg <= reqIn;
      cnt_reg <= changed ? 8'h00 : (done ? cnt_reg : cnt_reg + 8'h01);
      if (done && !changed)
        reqOut_reg <= held_reg;
    end
  end

  assign reqOut = reqOut_reg;

endmodule : cms_req_settle

// [src/cms_clk_route.sv]
// Output clock source, divide and fixed clock selection per mode
module cms_clk_route
  import cms_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  cms_route_if.route rt
);

  wire [11:0] pTimesN = 12'(cms_prescale(rt.range) * cms_mult(rt.multiplier_field));
  wire [11:0] rFactor = 12'h001 << rt.reduction_field;
  wire ratioOk = pTimesN >= 12'(FIXED_MIN_RATIO * rFactor);
  wire [3:0] shiftR = {1'b0, rt.reduction_field};

  logic [1:0] src_next;
  logic [3:0] div_next;
  logic [1:0] fix_next;
  logic [7:0] comp_next;
  logic [7:0] rdiv_next;

  always_comb
  begin
    src_next = SRC_DCO;
    div_next = shiftR;
    fix_next = FIX_BUS;
    comp_next = INT_COMP_PERIODS;
    rdiv_next = INT_REF_DIV;
    unique case (rt.state)
      ST_OFF:
      begin
        src_next = SRC_OFF;
        fix_next = FIX_OFF;
        comp_next = 8'h00;
        rdiv_next = 8'h00;
      end
      ST_SCM, ST_FEI: fix_next = FIX_OFF;
      ST_FBE:
      begin
        src_next = SRC_EXT;
        comp_next = 8'h00;
        rdiv_next = 8'h00;
      end
      ST_FEE:
      begin
        div_next = rt.halfRate ? shiftR + 4'h1 : shiftR;
        comp_next = rt.range ? EXT_COMP_HIGH : EXT_COMP_LOW;
        rdiv_next = 8'h01;
        fix_next = (ratioOk && rt.fllLock) ? FIX_EXT_HALF : FIX_BUS;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rt.genSource <= SRC_OFF;
      rt.genDivShift <= 4'h0;
      rt.fixedSel <= FIX_OFF;
      rt.compPeriods <= 8'h00;
      rt.refDivide <= 8'h00;
    end
    else
    begin
      rt.genSource <= src_next;
      rt.genDivShift <= div_next;
      rt.fixedSel <= fix_next;
      rt.compPeriods <= comp_next;
      rt.refDivide <= rdiv_next;
    end
  end

endmodule : cms_clk_route

// [src/cms_clock_mode_select.sv]
// Clock mode selection and status with APB register access
//
// Decided for this implementation: the placing of the registers and register access over APB.

module cms_clock_mode_select
  import cms_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscStable,
  input wire logic refFreqOk,
  input wire logic clockLoss,
  input wire logic fllLock,
  output logic [1:0] genSource,
  output logic [3:0] genDivShift,
  output logic [1:0] fixedSel,
  output logic [7:0] compPeriods,
  output logic [7:0] refDivide,
  output logic oscAmpEnable,
  output logic highGainSel
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Settle stage serves 2 to 255 cycles only
  if (SETTLE < 2 || SETTLE > 255)
  begin : g_bad_settle
    $error("cms_clock_mode_select: SETTLE out of range");
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // No wait states: access completes on its first edge
  wire setup = psel && !penable;
  wire wrStrobe = psel && penable && pwrite;
  wire hitCtrl1 = paddr == ADDR_CTRL1;
  wire hitCtrl2 = paddr == ADDR_CTRL2;
  wire hitStatus = paddr == ADDR_STATUS;
  wire mapped = hitCtrl1 || hitCtrl2 || hitStatus;
  wire wrCtrl1 = wrStrobe && hitCtrl1;
  wire wrCtrl2 = wrStrobe && hitCtrl2;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [1:0] modeReq_reg;
  logic range_reg;
  logic reference_select_reg;
  logic hgo_reg;
  logic firstWrDone_reg;
  logic hgoWritten_reg;
  logic [2:0] mfd_reg;
  logic [2:0] rfd_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic oscAmp_reg;
  logic highGain_reg;

  wire [2:0] mfdWr = pwdata[CTRL2_MFD +: 3];
  wire mfdChange = wrCtrl2 && (mfdWr != mfd_reg);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      modeReq_reg <= REQ_RESET;
      range_reg <= 1'b0;
      reference_select_reg <= 1'b0;
      hgo_reg <= 1'b0;
      firstWrDone_reg <= 1'b0;
      hgoWritten_reg <= 1'b0;
      mfd_reg <= FIELD_RESET;
      rfd_reg <= FIELD_RESET;
    end
    else
    begin
      if (wrCtrl1)
      begin
        modeReq_reg <= pwdata[CTRL1_REQ +: 2];
        range_reg <= pwdata[CTRL1_RANGE];
        firstWrDone_reg <= 1'b1;
        if (!firstWrDone_reg)
          reference_select_reg <= pwdata[CTRL1_REFERENCE_SELECT];
        if (!hgoWritten_reg)
        begin
          hgo_reg <= pwdata[CTRL1_HGO];
          hgoWritten_reg <= 1'b1;
        end
      end
      if (wrCtrl2)
      begin
        mfd_reg <= mfdWr;
        rfd_reg <= pwdata[CTRL2_RFD +: 3];
      end
    end
  end

  // ----------------------------------------
  // Request synchroniser
  // ----------------------------------------
  logic [1:0] reqSettled;

  cms_req_settle #(.SETTLE(SETTLE)) u_settle (
    .clock(clock),
    .rst(rst),
    .reqIn(modeReq_reg),
    .reqOut(reqSettled)
  );

  // ----------------------------------------
  // Reference status
  // ----------------------------------------
  wire extRequested = reqSettled[1];
  wire extClockInput = (reqSettled == MODE_FBE) && !reference_select_reg;
  wire extRefOk = extRequested && (extClockInput || refFreqOk);

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  cms_state_t state_reg;
  cms_state_t state_next;
  logic lockedOnce_reg;

  always_comb
  begin
    state_next = ST_SCM;
    unique case (reqSettled)
      MODE_SCM: state_next = ST_SCM;
      MODE_FEI: state_next = oscStable ? ST_FEI : ST_SCM;
      MODE_FBE:
        if (extRefOk)
          state_next = ST_FBE;
        else
          state_next = (state_reg == ST_OFF) ? ST_OFF : ST_SCM;
      MODE_FEE:
        if (clockLoss && extRefOk)
          state_next = ST_FBE;
        else if (!oscStable)
          state_next = ST_SCM;
        else if (!extRefOk)
          state_next = ST_FEI;
        else
          state_next = ST_FEE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_OFF;
      lockedOnce_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != ST_FEE || mfdChange)
        lockedOnce_reg <= 1'b0;
      else if (fllLock)
        lockedOnce_reg <= 1'b1;
    end
  end

  wire [1:0] modeActual = cms_code(state_reg);

  // ----------------------------------------
  // Clock routing
  // ----------------------------------------
  cms_route_if rt();

  assign rt.state = state_reg;
  assign rt.halfRate = !lockedOnce_reg;
  assign rt.fllLock = fllLock;
  assign rt.range = range_reg;
  assign rt.multiplier_field = mfd_reg;
  assign rt.reduction_field = rfd_reg;

  cms_clk_route u_route (
    .clock(clock),
    .rst(rst),
    .rt(rt.route)
  );

  assign genSource = rt.genSource;
  assign genDivShift = rt.genDivShift;
  assign fixedSel = rt.fixedSel;
  assign compPeriods = rt.compPeriods;
  assign refDivide = rt.refDivide;

  // ----------------------------------------
  // Oscillator controls and read data
  // ----------------------------------------
  wire ampNext = reference_select_reg && extRequested;
  wire hgNext = hgo_reg && reference_select_reg;
  wire [7:0] ctrl1Read = {hgo_reg, range_reg, reference_select_reg, modeReq_reg, 3'h0};
  wire [7:0] ctrl2Read = {1'b0, mfd_reg, 1'b0, rfd_reg};
  wire [7:0] statRead = {highGain_reg, oscAmp_reg, fllLock, clockLoss, extRefOk, oscStable, modeActual};
  wire [7:0] readSel = hitCtrl1 ? ctrl1Read : (hitCtrl2 ? ctrl2Read : (hitStatus ? statRead : 8'h00));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      oscAmp_reg <= 1'b0;
      highGain_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= 1'b1;
      if (setup)
      begin
        prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, readSel};
        pslverr_reg <= !mapped;
      end
      oscAmp_reg <= ampNext;
      highGain_reg <= hgNext;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign oscAmpEnable = oscAmp_reg;
  assign highGainSel = highGain_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fee_unlocked;
    state_reg == ST_FEE && !lockedOnce_reg;
  endsequence

  a_status_delayed: assert property (wrCtrl1 |=> modeActual == $past(modeActual))
    else $error("mode status changed right after request write");
  a_fei_entry: assert property (reqSettled == MODE_FEI && oscStable |=> state_reg == ST_FEI)
    else $error("internal engaged mode not entered");
  a_fbe_stays_off: assert property (state_reg == ST_OFF && reqSettled == MODE_FBE && !extRefOk
                                    |=> state_reg == ST_OFF ##1 genSource == SRC_OFF)
    else $error("bypassed request without reference left off state");
  a_loss_to_fbe: assert property (reqSettled == MODE_FEE && clockLoss && extRefOk |=> state_reg == ST_FBE)
    else $error("clock loss did not revert to bypassed mode");
  a_reference_select_locked: assert property (firstWrDone_reg |=> $stable(reference_select_reg))
    else $error("reference select changed after first write");
  a_hgo_once: assert property (hgoWritten_reg |=> $stable(hgo_reg))
    else $error("high gain bit changed twice");
  a_fixed_off: assert property (state_reg == ST_SCM || state_reg == ST_FEI |=> fixedSel == FIX_OFF)
    else $error("fixed clock running in internal mode");
  a_half_rate: assert property (s_fee_unlocked |=> genDivShift == {1'b0, $past(rfd_reg)} + 4'h1)
    else $error("unlocked engaged mode not at half rate");
  a_scm_divide: assert property (state_reg == ST_SCM |=> genSource == SRC_DCO && compPeriods == INT_COMP_PERIODS
                                 && refDivide == INT_REF_DIV)
    else $error("self clocked routing wrong");
  a_ext_ok: assert property (!refFreqOk && reference_select_reg |-> !extRefOk)
    else $error("reference ok without minimum frequency");

  // ----------------------------------------
  // Routing, oscillator control, reference status and bus error checks
  // ----------------------------------------
  sequence s_fee_locked;
    state_reg == ST_FEE && lockedOnce_reg;
  endsequence

  sequence s_bypass_run;
    state_reg == ST_FBE;
  endsequence

  // Once locked the extra halving is dropped
  a_locked_rate: assert property (s_fee_locked |=> genDivShift == {1'b0, $past(rfd_reg)})
    else $error("locked engaged mode not at full rate");
  a_bypass_route: assert property (s_bypass_run |=> genSource == SRC_EXT && fixedSel == FIX_BUS)
    else $error("bypassed routing wrong");
  a_fixed_unlock: assert property (state_reg == ST_FEE && !fllLock |=> fixedSel == FIX_BUS)
    else $error("fixed clock on reference without lock");
  // Amplifier only with latched reference select
  a_amp_follow: assert property (1'b1 |=> oscAmpEnable == $past(ampNext))
    else $error("amplifier enable does not follow request");
  a_gain_gated: assert property (!reference_select_reg |=> !highGainSel)
    else $error("high gain selected without reference select");
  a_ref_forced: assert property (!extRequested |-> !extRefOk)
    else $error("reference ok while internal mode requested");
  a_bus_error: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access without error");

endmodule : cms_clock_mode_select

// [testbench/cms_osc_partner.sv]
// Partner model: oscillator flags, lock detector and a fixed-clock peripheral
module cms_osc_partner
  import cms_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmdStable,
  input wire logic cmdRef,
  input wire logic cmdLoss,
  input wire logic cmdLock,
  input wire logic [1:0] genSource,
  input wire logic [1:0] fixedSel,
  output logic oscStable,
  output logic refFreqOk,
  output logic clockLoss,
  output logic fllLock,
  output logic fixedInUse
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Flags follow the commanded conditions, lock only while genSource is SRC_DCO
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      oscStable <= 1'b0;
      refFreqOk <= 1'b0;
      clockLoss <= 1'b0;
      fllLock <= 1'b0;
    end
    else
    begin
      oscStable <= cmdStable;
      refFreqOk <= cmdRef;
      clockLoss <= cmdLoss;
      fllLock <= cmdLock && genSource == SRC_DCO;
    end
  end

  // Peripheral only runs on the fixed clock while it is on
  assign fixedInUse = fixedSel != FIX_OFF;
endmodule : cms_osc_partner

// [testbench/cms_clock_mode_select_tb.sv]
// Testbench of the clock mode selector
module cms_clock_mode_select_tb;
  import cms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SET = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, rdErr;
  logic cmdStable = 1'b0, cmdRef = 1'b0, cmdLoss = 1'b0, cmdLock = 1'b0;
  logic oscStable, refFreqOk, clockLoss, fllLock, oscAmpEnable, highGainSel, fixedInUse;
  logic [1:0] genSource, fixedSel;
  logic [3:0] genDivShift;
  logic [7:0] compPeriods, refDivide;
  int errTotal = 0;
  int checks = 0;

  cms_clock_mode_select #(.SETTLE(SET)) DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscStable(oscStable), .refFreqOk(refFreqOk), .clockLoss(clockLoss), .fllLock(fllLock),
    .genSource(genSource), .genDivShift(genDivShift), .fixedSel(fixedSel), .compPeriods(compPeriods),
    .refDivide(refDivide), .oscAmpEnable(oscAmpEnable), .highGainSel(highGainSel));

  cms_osc_partner osc (.clock(clock), .rst(rst), .cmdStable(cmdStable), .cmdRef(cmdRef), .cmdLoss(cmdLoss),
    .cmdLock(cmdLock), .genSource(genSource), .fixedSel(fixedSel), .oscStable(oscStable),
    .refFreqOk(refFreqOk), .clockLoss(clockLoss), .fllLock(fllLock), .fixedInUse(fixedInUse));

  always #5 clock = ~clock;

  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
      chk("pready", 32'h1, 32'h0);
  endtask : apb

  task automatic stat(input string nm, input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, ADDR_STATUS, 8'h00);
    chk(nm, {24'h0, exp}, rdData & {24'h0, mask});
  endtask : stat

  task automatic flags(input logic s, input logic r, input logic l, input logic k);
    @(posedge clock);
    cmdStable <= s;
    cmdRef <= r;
    cmdLoss <= l;
    cmdLock <= k;
    repeat (SET + 4) @(posedge clock);
  endtask : flags

  task automatic doReset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask : doReset

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5000) @(posedge clock);
    errTotal++;
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    doReset();
    flags(1'b0, 1'b1, 1'b0, 1'b0);
    stat("mode after reset", 8'h03, MODE_SCM);
    apb(1'b0, 8'h0C, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, rdErr});
    chk("unmapped data", 32'h0, rdData);
    $display("test reset done");
    apb(1'b1, ADDR_CTRL1, 8'hB8);
    flags(1'b0, 1'b1, 1'b0, 1'b0);
    stat("scm fallback", 8'h03, MODE_SCM);
    stat("amp and gain", 8'hC0, 8'hC0);
    chk("scm source", SRC_DCO, genSource);
    chk("scm ref div", 32'h7, refDivide);
    chk("scm compare", 32'h8, compPeriods);
    chk("scm fixed", FIX_OFF, fixedSel);
    flags(1'b1, 1'b0, 1'b0, 1'b0);
    stat("fei fallback", 8'h03, MODE_FEI);
    chk("fei fixed", FIX_OFF, fixedSel);
    chk("fei periph", 32'h0, fixedInUse);
    $display("test fallback done");
    apb(1'b1, ADDR_CTRL2, 8'h03);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    stat("fee entry", 8'h03, MODE_FEE);
    chk("fee half rate", 32'h4, genDivShift);
    chk("fee compare low", 32'h2, compPeriods);
    chk("fee fixed unlocked", FIX_BUS, fixedSel);
    flags(1'b1, 1'b1, 1'b0, 1'b1);
    chk("fee locked rate", 32'h3, genDivShift);
    chk("fee fixed ext", FIX_EXT_HALF, fixedSel);
    apb(1'b1, ADDR_CTRL2, 8'h07);
    flags(1'b1, 1'b1, 1'b0, 1'b1);
    chk("ratio two", FIX_BUS, fixedSel);
    apb(1'b1, ADDR_CTRL2, 8'h27);
    flags(1'b1, 1'b1, 1'b0, 1'b1);
    chk("ratio four", FIX_EXT_HALF, fixedSel);
    apb(1'b1, ADDR_CTRL1, 8'h78);
    flags(1'b1, 1'b1, 1'b0, 1'b1);
    chk("high range fixed", FIX_BUS, fixedSel);
    chk("fee compare high", 32'h80, compPeriods);
    stat("gain kept", 8'h80, 8'h80);
    $display("test engaged done");
    flags(1'b1, 1'b1, 1'b1, 1'b0);
    stat("loss bypass", 8'h03, MODE_FBE);
    chk("fbe source", SRC_EXT, genSource);
    chk("fbe fixed", FIX_BUS, fixedSel);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL1, 8'h68);
    stat("status delayed", 8'h03, MODE_FEE);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    stat("fei request", 8'h0B, MODE_FEI);
    $display("test request done");
    doReset();
    apb(1'b1, ADDR_CTRL1, 8'h90);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    stat("bypass forced", 8'h03, MODE_FBE);
    chk("amp locked off", 32'h0, oscAmpEnable);
    chk("gain needs ref", 32'h0, highGainSel);
    apb(1'b1, ADDR_CTRL1, 8'hB0);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    stat("ref stays off", 8'hC0, 8'h00);
    apb(1'b1, ADDR_CTRL1, 8'h00);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    stat("back to scm", 8'h03, MODE_SCM);
    $display("test second reset done");
    conclude();
  end
endmodule : cms_clock_mode_select_tb
